// [bench/lmh_dte_model.sv]
/*
  Behavioural terminal on the far side of the modem's serial port.
  Assumes the bench steers its wish to send and that cts comes back registered.
*/
`timescale 1ns/1ps
`default_nettype none
module lmh_dte_model (
  // clock
  input  wire logic ref_clk,
  // bench control
  input  wire logic want,
  // modem handshake and data
  input  wire logic dteCts,
  output logic      dteRts,
  output logic      dteTxd
);
  logic [7:0] shreg;
  logic       go;

  // rts is raised the moment the bench wants to send
  assign dteRts = want;
  assign go     = want & dteCts;

  // character shifts only after cts has answered; reloads while waiting
  always_ff @(posedge ref_clk)
  begin
    shreg <= go ? {shreg[0], shreg[7:1]} : 8'hB4;
  end

  // line sits at mark until the modem lets us talk
  assign dteTxd = go ? shreg[0] : 1'h1;
endmodule : lmh_dte_model
`default_nettype wire

// [bench/tb_line_modem_handshake_mode_ctl.sv]
/*
  Self-checking bench for the modem handshake and mode control.
  Assumes short debounce, flash and delay counts set through parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_line_modem_handshake_mode_ctl;
  import lmh_pkg::*;
  localparam int CB = 20;
  localparam int FL = 8;
  typedef struct {logic [7:0] ctrl; int mul; logic [1:0] eq;} lmh_row_s;
  lmh_row_s rows [4] = '{'{8'h18, 8, 2'h0}, '{8'h11, 4, 2'h1}, '{8'h0A, 2, 2'h2}, '{8'h03, 1, 2'h3}};
  logic        ref_clk = 1'h0;  // only the clock process writes it afterwards
  logic        resetn, regWr, regRd, want, modeButton;
  logic [3:0]  regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic        dteRts, dteTxd, dteCts, dteRxd, lineTxData, lineTxEnable;
  logic        lineRxData, lineRxCarrier, lineTxCarrier;
  logic [1:0]  eqLevel;
  logic        carrierIndicator, testIndicatorUpper, testIndicatorLower;
  logic        ctsIndicator, rtsIndicator, rxActIndicator, txActIndicator;
  int          failCount, nTests, n;

  lmh_ctl #(.CTS_BASE_CYCLES(CB), .DEBOUNCE_CYCLES(4), .FLASH_CYCLES(FL)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .dteRts(dteRts), .dteTxd(dteTxd),
    .dteCts(dteCts), .dteRxd(dteRxd), .lineRxData(lineRxData), .lineRxCarrier(lineRxCarrier),
    .lineTxCarrier(lineTxCarrier), .lineTxData(lineTxData), .lineTxEnable(lineTxEnable),
    .eqLevel(eqLevel), .modeButton(modeButton), .carrierIndicator(carrierIndicator),
    .testIndicatorUpper(testIndicatorUpper), .testIndicatorLower(testIndicatorLower),
    .ctsIndicator(ctsIndicator), .rtsIndicator(rtsIndicator),
    .rxActIndicator(rxActIndicator), .txActIndicator(txActIndicator));

  lmh_dte_model i_dte (.ref_clk(ref_clk), .want(want), .dteCts(dteCts), .dteRts(dteRts), .dteTxd(dteTxd));

  // 20 MHz
  always #25 ref_clk = ~ref_clk;

  task final_report;
    if (failCount == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      failCount++;
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'h1;
    @(posedge ref_clk);
    regWr <= 1'h0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge ref_clk);
    regRd <= 1'h0;
    @(negedge ref_clk);
    v = regRdata;
  endtask : rd

  // release needs the full debounce window too, hence the long tail
  task press(input int len);
    @(posedge ref_clk) modeButton <= 1'h1;
    repeat (len) @(posedge ref_clk);
    modeButton <= 1'h0;
    repeat (14) @(posedge ref_clk);
  endtask : press

  // output must echo the terminal data one cycle later
  task follow(input int sel);
    logic p;
    repeat (12)
    begin
      @(negedge ref_clk);
      p = dteTxd;
      @(negedge ref_clk);
      chk("follow", p, sel ? dteRxd : lineTxData);
    end
  endtask : follow

  // cycles until the watched lamp or data line changes; call on a falling edge
  task wait_chg(input int sel, output int c);
    logic v;
    v = sel ? carrierIndicator : dteRxd;
    c = 0;
    while ((sel ? carrierIndicator : dteRxd) === v && c < 3000)
    begin
      @(negedge ref_clk);
      c++;
    end
  endtask : wait_chg

  // watchdog sized well past the longest expected run
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    failCount++;
    final_report();
  end

  initial
  begin
    {resetn, regWr, regRd, want, modeButton, lineTxCarrier, lineRxCarrier} = 7'h0;
    {regAddr, regWdata, lineRxData} = 37'h1;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'h1;
    // delay choices and switch codes, one row each
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL, 32'(rows[i].ctrl));
      rd(ADDR_CTRL, d);
      chk("ctrl", 32'(rows[i].ctrl), d);
      chk("eq", rows[i].eq, eqLevel);
      @(posedge ref_clk) want <= 1'h1;
      n = 0;
      while (dteCts !== 1'h1 && n < 400)
      begin
        @(negedge ref_clk);
        n++;
      end
      chk("ctsdly", 1, n >= CB * rows[i].mul + 3 && n <= CB * rows[i].mul + 4);
      repeat (2) @(negedge ref_clk);
      chk("lamps", 4'hF, {ctsIndicator, rtsIndicator, txActIndicator, lineTxEnable});
      rd(ADDR_STATUS, d);
      chk("status", 32'({rows[i].eq, 6'h0C}), d);
      follow(0);
      @(posedge ref_clk) want <= 1'h0;
      repeat (3) @(negedge ref_clk);
      chk("ctsoff", 2'h0, {dteCts, lineTxEnable});
    end
    // busy detect holds cts off until the transmit carrier goes
    wr(ADDR_CTRL, 32'h1F);
    lineTxCarrier <= 1'h1;
    want          <= 1'h1;
    repeat (60) @(negedge ref_clk);
    rd(ADDR_STATUS, d);
    chk("busy", 32'h28, d);
    chk("busycts", 1'h0, dteCts);
    @(posedge ref_clk) lineTxCarrier <= 1'h0;
    repeat (4) @(negedge ref_clk);
    chk("busyend", 1'h1, dteCts);
    @(posedge ref_clk) want <= 1'h0;
    // a short bounce must not step the mode
    press(2);
    chk("bounce", 2'h0, {testIndicatorUpper, testIndicatorLower});
    press(10);
    lineRxData    <= 1'h0;
    lineRxCarrier <= 1'h1;
    repeat (3) @(negedge ref_clk);
    chk("modeA", 7'h53, {testIndicatorUpper, testIndicatorLower, lineTxEnable, lineTxData, dteCts,
      dteRxd, carrierIndicator});
    press(10);
    want <= 1'h1;
    repeat (30) @(negedge ref_clk);
    follow(1);
    chk("modeB", 5'h0A, {testIndicatorUpper, testIndicatorLower, lineTxEnable, lineTxData,
      carrierIndicator});
    press(10);
    @(negedge ref_clk);
    chk("modeC", 5'h19, {testIndicatorUpper, testIndicatorLower, dteCts, lineTxEnable, rxActIndicator});
    wait_chg(0, n);
    wait_chg(0, n);
    chk("baud", BAUD_CYC, n);
    wait_chg(1, n);
    wait_chg(1, n);
    chk("flash", FL, n);
    press(10);
    chk("wrap", 2'h0, {testIndicatorUpper, testIndicatorLower});
    // normal path passes bits at whatever pace the far end uses
    for (int i = 0; i < 6; i++)
    begin
      @(posedge ref_clk) lineRxData <= i[0] ^ i[2];
      repeat (2) @(negedge ref_clk);
      chk("rxpath", {i[0] ^ i[2], 2'h3}, {dteRxd, carrierIndicator, rxActIndicator});
    end
    // a reset in mid-run lands back in normal mode
    press(10);
    @(posedge ref_clk) resetn <= 1'h0;
    repeat (2) @(negedge ref_clk);
    chk("rstlamps", 3'h0, {testIndicatorUpper, testIndicatorLower, dteCts});
    @(posedge ref_clk) resetn <= 1'h1;
    rd(ADDR_CTRL, d);
    chk("ctrlrst", 32'h1B, d);
    rd(4'h8, d);
    chk("unmapped", 32'h0, d);
    rd(ADDR_STATUS, d);
    // rts is still up from the terminal, so its status bit stands
    chk("statrst", 32'h18, d);
    chk("eqrst", EQ_LEVEL1, eqLevel);
    final_report();
  end
endmodule : tb_line_modem_handshake_mode_ctl
`default_nettype wire

// [rtl/lmh_btn_if.sv]
/*
  Carrier for the cleaned mode pushbutton between the debouncer and the
  control logic. Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface lmh_btn_if;
  logic press;   // one-cycle pulse per physical press
  logic held;    // debounced level

  modport src (output press, held);
  modport dst (input press, held);
endinterface : lmh_btn_if
`default_nettype wire

// [rtl/lmh_ctl.sv]
/*
  Handshake, mode and indicator control of a limited-distance line modem
  acting as DCE toward an asynchronous RS-232 terminal.
  Assumes ref_clk at 20 MHz, line data already demodulated to logic levels,
  and terminal pins already at logic levels and synchronous to ref_clk.
*/
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
// How it works
// - after rts rises, cts is raised once the selected delay has elapsed, 8 ms out of reset.
// - the delay selector offers exactly 64, 32, 16 or 8 ms, one choice at a time.
// - with busy detect enabled, cts is held off while the transmit channel carries a carrier.
// - in normal mode line data goes out only while rts is high and cts has answered; the terminal waits for cts.
// - equalization switches both on give level 1, off-on 2, on-off 3, both off 4.
// - equalization resets to level 1.
// - the serial data passes bit by bit, so any terminal bit rate works.
// - the mode is normal right after power-up.
// - each button press steps normal, test A, test B, test C and back to normal.
// - test lamps are off-off for normal, upper for A, lower for B, both for C.
// - the carrier lamp follows receive carrier in normal mode and test A, stays off in test B and flashes during test C.
// - the cts lamp shows the rts-to-cts handshake state even where cts to the terminal stays low, and the rts lamp shows rts.
// - in normal mode the receive activity lamp follows receive carrier and the transmit activity lamp shows rts with cts.
// - test C sends an alternating 19,200 baud pattern to the terminal receive data, not the line, and ignores the handshake.
// - test B loops terminal transmit data to receive and sends nothing to the line.
`timescale 1ns/1ps
`default_nettype none
module lmh_ctl #(
  parameter int unsigned CTS_BASE_CYCLES = lmh_pkg::CTS_BASE_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = lmh_pkg::DEBOUNCE_CYC,
  parameter int unsigned FLASH_CYCLES    = lmh_pkg::FLASH_CYC
)(
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       resetn,
  // register port
  input  wire logic [lmh_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [lmh_pkg::DATA_W-1:0] regWdata,
  input  wire logic                       regWr,
  input  wire logic                       regRd,
  output logic      [lmh_pkg::DATA_W-1:0] regRdata,
  // terminal side
  input  wire logic                       dteRts,
  input  wire logic                       dteTxd,
  output logic                            dteCts,
  output logic                            dteRxd,
  // line side, demodulated
  input  wire logic                       lineRxData,
  input  wire logic                       lineRxCarrier,
  input  wire logic                       lineTxCarrier,
  output logic                            lineTxData,
  output logic                            lineTxEnable,
  output logic      [1:0]                 eqLevel,
  // front panel
  input  wire logic                       modeButton,
  output logic                            carrierIndicator,
  output logic                            testIndicatorUpper,
  output logic                            testIndicatorLower,
  output logic                            ctsIndicator,
  output logic                            rtsIndicator,
  output logic                            rxActIndicator,
  output logic                            txActIndicator
);
  import lmh_pkg::*;

  localparam logic [FLASH_W-1:0] FLASH_LAST = FLASH_W'(FLASH_CYCLES - 1);

  // equalization switch pair to level minus one
  function automatic logic [1:0] decodeEq(input logic [1:0] sw);
    logic [1:0] lvl;
    unique case (sw)          // {switch two on, switch one on}
      2'h3:    lvl = EQ_LEVEL1;
      2'h2:    lvl = EQ_LEVEL2;
      2'h1:    lvl = EQ_LEVEL3;
      default: lvl = EQ_LEVEL4;
    endcase
    return lvl;
  endfunction : decodeEq

  // selector code to delay in cycles
  function automatic logic [DLY_W-1:0] delayCycles(input logic [1:0] sel);
    logic [DLY_W-1:0] base;
    base = DLY_W'(CTS_BASE_CYCLES);
    unique case (sel)
      DLY_SEL_64MS: delayCycles = base << 3;
      DLY_SEL_32MS: delayCycles = base << 2;
      DLY_SEL_16MS: delayCycles = base << 1;
      DLY_SEL_8MS:  delayCycles = base;
    endcase
  endfunction : delayCycles

  lmh_btn_if btn ();

  lmh_debounce #(
    .STABLE_CYCLES (DEBOUNCE_CYCLES)
  ) u_debounce (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .rawButton (modeButton),
    .btn       (btn.src)
  );

  // control register and mode
  logic [1:0]         delaySel;
  logic               busyEn;
  logic [1:0]         eqSw;
  lmh_mode_e          mode;
  logic [1:0]         next_delaySel;
  logic               next_busyEn;
  logic [1:0]         next_eqSw;
  lmh_mode_e          next_mode;
  logic [DATA_W-1:0]  next_regRdata;
  logic [DATA_W-1:0]  statusWord;
  logic [DATA_W-1:0]  ctrlWord;

  // handshake
  logic [DLY_W-1:0]   delayCnt;
  logic               ctsState;
  logic [DLY_W-1:0]   next_delayCnt;
  logic               next_ctsState;
  logic [DLY_W-1:0]   delayTarget;
  logic               busyHold;

  // test pattern and flash
  logic [BAUD_W-1:0]  baudCnt;
  logic               genBit;
  logic [FLASH_W-1:0] flashCnt;
  logic               flashBit;
  logic [BAUD_W-1:0]  next_baudCnt;
  logic               next_genBit;
  logic [FLASH_W-1:0] next_flashCnt;
  logic               next_flashBit;

  // registered outputs
  logic               next_dteCts;
  logic               next_dteRxd;
  logic               next_lineTxData;
  logic               next_lineTxEnable;
  logic               next_carrierInd;
  logic               next_rxAct;
  logic               next_txAct;

  assign delayTarget = delayCycles(delaySel);
  assign busyHold    = busyEn && lineTxCarrier;

  assign ctrlWord = {{(DATA_W-5){1'b0}}, eqSw, busyEn, delaySel};
  assign statusWord = {{(DATA_W-8){1'b0}}, decodeEq(eqSw), busyHold,
                       lineRxCarrier, dteRts, ctsState, mode};

  // register writes and single-cycle read answer; unmapped reads give zero
  always_comb
  begin
    next_delaySel = delaySel;
    next_busyEn   = busyEn;
    next_eqSw     = eqSw;
    next_regRdata = '0;
    if (regWr && regAddr == ADDR_CTRL)
    begin
      next_delaySel = regWdata[CTRL_DLY_LSB +: 2];
      next_busyEn   = regWdata[CTRL_BUSY_BIT];
      next_eqSw     = {regWdata[CTRL_EQ2_BIT], regWdata[CTRL_EQ1_BIT]};
    end
    if (regRd)
    begin
      if (regAddr == ADDR_CTRL)
        next_regRdata = ctrlWord;
      else if (regAddr == ADDR_STATUS)
        next_regRdata = statusWord;
    end
  end

  // mode steps once per cleaned press
  always_comb
  begin
    next_mode = mode;
    if (btn.press)
    begin
      unique case (mode)
        MODE_NORMAL: next_mode = MODE_A;
        MODE_A:      next_mode = MODE_B;
        MODE_B:      next_mode = MODE_C;
        MODE_C:      next_mode = MODE_NORMAL;
      endcase
    end
  end

  // rts-to-cts delay; a dropped rts restarts the wait from zero
  always_comb
  begin
    next_delayCnt = delayCnt;
    next_ctsState = ctsState;
    if (!dteRts)
    begin
      next_delayCnt = '0;
      next_ctsState = 1'b0;
    end
    else if (!ctsState)
    begin
      if (delayCnt < delayTarget)
        next_delayCnt = delayCnt + 1'b1;
      else if (!busyHold)
        next_ctsState = 1'b1;
    end
  end

  // test C pattern generator and carrier lamp flasher, idle elsewhere
  always_comb
  begin
    next_baudCnt  = '0;
    next_genBit   = MARK;
    next_flashCnt = '0;
    next_flashBit = 1'b0;
    if (mode == MODE_C)
    begin
      next_genBit   = genBit;
      next_flashBit = flashBit;
      if (baudCnt == BAUD_LAST)
        next_genBit = !genBit;
      else
        next_baudCnt = baudCnt + 1'b1;
      if (flashCnt == FLASH_LAST)
        next_flashBit = !flashBit;
      else
        next_flashCnt = flashCnt + 1'b1;
    end
  end

  // data routing and lamps per mode; serial bits pass through unclocked by any baud
  always_comb
  begin
    next_dteCts       = 1'b0;
    next_dteRxd       = MARK;
    next_lineTxData   = MARK;
    next_lineTxEnable = 1'b0;
    next_carrierInd   = 1'b0;
    next_rxAct        = 1'b0;
    next_txAct        = 1'b0;
    unique case (mode)
      MODE_NORMAL:
      begin
        next_dteCts       = ctsState;
        next_dteRxd       = lineRxData;
        next_lineTxEnable = dteRts && ctsState;
        next_lineTxData   = (dteRts && ctsState) ? dteTxd : MARK;
        next_carrierInd   = lineRxCarrier;
        next_rxAct        = lineRxCarrier;
        next_txAct        = dteRts && ctsState;
      end
      MODE_A:
      begin
        // terminal cut off; received data turned round onto the line
        next_lineTxEnable = lineRxCarrier;
        next_lineTxData   = lineRxData;
        next_carrierInd   = lineRxCarrier;
      end
      MODE_B:
      begin
        // loop needs no rts; the line sees only idle
        next_dteCts = ctsState;
        next_dteRxd = dteTxd;
        next_rxAct  = !dteTxd;
        next_txAct  = !dteTxd;
      end
      MODE_C:
      begin
        // handshake ignored: cts to the terminal stays low
        next_dteRxd     = genBit;
        next_carrierInd = flashBit;
        next_rxAct      = 1'b1;
        next_txAct      = !dteTxd;
      end
    endcase
  end

  // all state and outputs; reset gives normal mode and factory settings
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      delaySel           <= DLY_SEL_8MS;
      busyEn             <= 1'b0;
      eqSw               <= EQ_SW_DEFAULT;
      mode               <= MODE_NORMAL;
      regRdata           <= '0;
      delayCnt           <= '0;
      ctsState           <= 1'b0;
      baudCnt            <= '0;
      genBit             <= MARK;
      flashCnt           <= '0;
      flashBit           <= 1'b0;
      dteCts             <= 1'b0;
      dteRxd             <= MARK;
      lineTxData         <= MARK;
      lineTxEnable       <= 1'b0;
      eqLevel            <= EQ_LEVEL1;
      carrierIndicator   <= 1'b0;
      testIndicatorUpper <= 1'b0;
      testIndicatorLower <= 1'b0;
      ctsIndicator       <= 1'b0;
      rtsIndicator       <= 1'b0;
      rxActIndicator     <= 1'b0;
      txActIndicator     <= 1'b0;
    end
    else
    begin
      delaySel           <= next_delaySel;
      busyEn             <= next_busyEn;
      eqSw               <= next_eqSw;
      mode               <= next_mode;
      regRdata           <= next_regRdata;
      delayCnt           <= next_delayCnt;
      ctsState           <= next_ctsState;
      baudCnt            <= next_baudCnt;
      genBit             <= next_genBit;
      flashCnt           <= next_flashCnt;
      flashBit           <= next_flashBit;
      dteCts             <= next_dteCts;
      dteRxd             <= next_dteRxd;
      lineTxData         <= next_lineTxData;
      lineTxEnable       <= next_lineTxEnable;
      eqLevel            <= decodeEq(eqSw);
      carrierIndicator   <= next_carrierInd;
      testIndicatorUpper <= (mode == MODE_A) || (mode == MODE_C);
      testIndicatorLower <= (mode == MODE_B) || (mode == MODE_C);
      ctsIndicator       <= ctsState;
      rtsIndicator       <= dteRts;
      rxActIndicator     <= next_rxAct;
      txActIndicator     <= next_txAct;
    end
  end

  cts_not_early_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(ctsState) |-> $past(dteRts) && ($past(delayCnt) == $past(delayTarget)))
    else $error("cts raised before the delay ran out");

  cts_drop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !dteRts |=> !ctsState && delayCnt == '0)
    else $error("cts or delay count kept after rts fell");

  busy_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    busyEn && lineTxCarrier && !ctsState |=> !ctsState)
    else $error("cts raised while transmit channel busy");

  tx_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_NORMAL && !(dteRts && ctsState) |=> !lineTxEnable && lineTxData == MARK)
    else $error("line transmit without rts and cts");

  eq_decode_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    eqSw == 2'h1 ##1 eqSw == 2'h1 |-> eqLevel == EQ_LEVEL3)
    else $error("equalization switch one on, two off not level 3");

  mode_wrap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    btn.press && mode == MODE_C |=> mode == MODE_NORMAL ##1 !testIndicatorUpper && !testIndicatorLower)
    else $error("mode did not wrap to normal");

  mode_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !btn.press |=> $stable(mode))
    else $error("mode changed without a press");

  test_lamps_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_B |=> !testIndicatorUpper && testIndicatorLower)
    else $error("test lamps wrong in test B");

  gen_rate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_C && $past(mode) == MODE_C && $changed(genBit) |-> $past(baudCnt) == BAUD_LAST)
    else $error("test pattern bit changed off the baud tick");

  loop_b_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    mode == MODE_B |=> !lineTxEnable && dteRxd == $past(dteTxd))
    else $error("test B loop or line isolation broken");

endmodule : lmh_ctl
`default_nettype wire

// [rtl/lmh_debounce.sv]
/*
  Pushbutton synchroniser and debouncer for the mode select button.
  Assumes an active-high raw button level, asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module lmh_debounce #(
  parameter int unsigned STABLE_CYCLES = lmh_pkg::DEBOUNCE_CYC
)(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // raw contact
  input  wire logic rawButton,
  // cleaned button
  lmh_btn_if.src    btn
);
  import lmh_pkg::*;

  localparam logic [DEB_W-1:0] STABLE_LAST = DEB_W'(STABLE_CYCLES - 1);

  logic             syncA;
  logic             syncB;
  logic             level;
  logic [DEB_W-1:0] stableCnt;
  logic             pressPulse;
  logic             next_level;
  logic [DEB_W-1:0] next_stableCnt;
  logic             next_pressPulse;

  // a new level is accepted only after it stays put for the whole window
  always_comb
  begin
    next_level      = level;
    next_stableCnt  = '0;
    next_pressPulse = 1'b0;
    if (syncB != level)
    begin
      if (stableCnt == STABLE_LAST)
      begin
        next_level      = syncB;
        next_pressPulse = syncB;   // one pulse on each accepted press
      end
      else
      begin
        next_stableCnt = stableCnt + 1'b1;
      end
    end
  end

  // two-stage synchroniser, then filter state
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      syncA      <= 1'b0;
      syncB      <= 1'b0;
      level      <= 1'b0;
      stableCnt  <= '0;
      pressPulse <= 1'b0;
    end
    else
    begin
      syncA      <= rawButton;
      syncB      <= syncA;
      level      <= next_level;
      stableCnt  <= next_stableCnt;
      pressPulse <= next_pressPulse;
    end
  end

  assign btn.press = pressPulse;
  assign btn.held  = level;

  press_single_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    pressPulse |=> !pressPulse && level)
    else $error("button press pulse longer than one cycle");

endmodule : lmh_debounce
`default_nettype wire

// [rtl/lmh_pkg.sv]
/*
  Shared constants for the line modem handshake and mode control logic:
  clock rate, timing counts, register map, field positions and the mode type.
  Assumes a single 20 MHz clock domain; no other surroundings needed.
*/
package lmh_pkg;

  // clock and derived timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned CTS_BASE_MS     = 8;     // shortest rts-to-cts choice
  localparam int unsigned CTS_BASE_CYC    = CYC_PER_MS * CTS_BASE_MS;
  localparam int unsigned DLY_W           = 21;    // holds 64 ms worth of cycles
  localparam int unsigned TEST_BAUD       = 19_200;
  localparam int unsigned BAUD_CYC        = CLK_HZ / TEST_BAUD;  // rounded down
  localparam int unsigned BAUD_W          = 11;
  localparam logic [BAUD_W-1:0] BAUD_LAST = BAUD_W'(BAUD_CYC - 1);
  localparam int unsigned DEBOUNCE_MS     = 10;
  localparam int unsigned DEBOUNCE_CYC    = CYC_PER_MS * DEBOUNCE_MS;
  localparam int unsigned DEB_W           = 18;
  localparam int unsigned FLASH_MS        = 250;   // carrier lamp half period in test C
  localparam int unsigned FLASH_CYC       = CYC_PER_MS * FLASH_MS;
  localparam int unsigned FLASH_W         = 23;

  // delay selector codes: one choice active at a time
  localparam logic [1:0] DLY_SEL_64MS = 2'h0;
  localparam logic [1:0] DLY_SEL_32MS = 2'h1;
  localparam logic [1:0] DLY_SEL_16MS = 2'h2;
  localparam logic [1:0] DLY_SEL_8MS  = 2'h3;

  // register bus
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;

  // control register fields
  localparam int unsigned CTRL_DLY_LSB  = 0;
  localparam int unsigned CTRL_BUSY_BIT = 2;
  localparam int unsigned CTRL_EQ1_BIT  = 3;   // switch one closed (on)
  localparam int unsigned CTRL_EQ2_BIT  = 4;   // switch two closed (on)
  localparam logic [1:0]  EQ_SW_DEFAULT = 2'h3;  // both on: minimum level

  // status register fields
  localparam int unsigned STAT_MODE_LSB = 0;
  localparam int unsigned STAT_CTS_BIT  = 2;
  localparam int unsigned STAT_RTS_BIT  = 3;
  localparam int unsigned STAT_CD_BIT   = 4;
  localparam int unsigned STAT_BUSY_BIT = 5;
  localparam int unsigned STAT_EQ_LSB   = 6;

  // line idle level
  localparam logic MARK = 1'b1;

  // equalization level minus one
  localparam logic [1:0] EQ_LEVEL1 = 2'h0;
  localparam logic [1:0] EQ_LEVEL2 = 2'h1;
  localparam logic [1:0] EQ_LEVEL3 = 2'h2;
  localparam logic [1:0] EQ_LEVEL4 = 2'h3;

  typedef enum logic [1:0] {MODE_NORMAL, MODE_A, MODE_B, MODE_C} lmh_mode_e;

endpackage : lmh_pkg
